/* File: include/gauge_pkg.sv */
// constants and types shared by the fuel gauge bus slave and its accumulators
package gauge_pkg;
    localparam int CLK_MHZ          = 250;
    localparam int HALF_SEC_MS      = 500;
    localparam int NV_WRITE_MS      = 4;
    localparam int HALF_SEC_CYCLES  = HALF_SEC_MS * CLK_MHZ * 1000;
    localparam int NV_WRITE_CYCLES  = NV_WRITE_MS * CLK_MHZ * 1000;

    localparam int NV_BYTES         = 256;
    localparam int SRAM_BYTES       = 32;
    localparam int ACC_COUNT        = 4;

    localparam logic [1:0] BANK_NV  = 2'h0;
    localparam logic [1:0] BANK_REG = 2'h1;

    localparam logic [9:0] SRAM_LAST   = 10'h01F;
    localparam logic [9:0] ACC_FIRST   = 10'h020;
    localparam logic [9:0] ACC_LAST    = 10'h02F;
    localparam logic [9:0] CTRL_ADDR   = 10'h030;
    localparam logic [9:0] CLEAR_ADDR  = 10'h031;
    localparam logic [9:0] STATUS_ADDR = 10'h032;
    localparam logic [9:0] CUR_LO_ADDR = 10'h040;
    localparam logic [9:0] CUR_HI_ADDR = 10'h041;

    localparam int CTRL_ACC_EN      = 0;
    localparam int CTRL_PEC_EN      = 1;
    localparam int STAT_NV_BUSY     = 0;
    localparam int STAT_PEC_ERR     = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;

    localparam int ACC_DIS_SUM      = 0;
    localparam int ACC_DIS_TIME     = 1;
    localparam int ACC_CHG_SUM      = 2;
    localparam int ACC_CHG_TIME     = 3;

    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [6:0] SLAVE_ADDR_DFLT = 7'h2A;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RECV    = 3'b001,
        ST_ACK_OUT = 3'b011,
        ST_SEND    = 3'b010,
        ST_ACK_IN  = 3'b110
    } link_state_t;
endpackage

/* File: include/acc_if.sv */
// control and value path between the bus slave and one accumulator
interface acc_if;
    logic        clear;
    logic        add;
    logic [31:0] step;
    logic [31:0] value;
    modport ctl  (output clear, output add, output step, input value);
    modport unit (input clear, input add, input step, output value);
endinterface

/* File: design/accum_unit.sv */
// one wrapping 32-bit accumulator or time counter
module accum_unit (
    input  wire logic clk,    // core clock
    input  wire logic rst_n,  // synchronous reset, active low
    acc_if.unit       port    // clear, add strobe, step and value
);
    logic [31:0] value_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_r <= 32'h0;
        end else if (port.clear) begin
            value_r <= 32'h0;
        end else if (port.add) begin
            value_r <= value_r + port.step;
        end
    end

    assign port.value = value_r;
endmodule

/* File: design/gauge_smbus_slave_memory_accum.sv */
// two-wire slave with banked memory, scratch sram and charge accumulators
module gauge_smbus_slave_memory_accum #(
    parameter logic [6:0] SLAVE_ADDR      = gauge_pkg::SLAVE_ADDR_DFLT,
    parameter int         HALF_SEC_CYCLES = gauge_pkg::HALF_SEC_CYCLES,
    parameter int         NV_WRITE_CYCLES = gauge_pkg::NV_WRITE_CYCLES
) (
    input  wire logic        clk,        // core clock, 250 MHz
    input  wire logic        rst_n,      // core synchronous reset, active low
    input  wire logic        adc_clk,    // converter clock
    input  wire logic        adc_rst_n,  // converter synchronous reset, active low
    input  wire logic [15:0] adc_result, // signed current result
    input  wire logic        adc_valid,  // result strobe, adc_clk domain
    input  wire logic        scl_i,      // serial clock level
    input  wire logic        sda_i,      // serial data level
    output logic             sda_o,      // serial data drive value, always low
    output logic             sda_oe      // high while pulling data low
);
    if (HALF_SEC_CYCLES < 1 || NV_WRITE_CYCLES < 1) begin : g_chk
        $error("cycle counts must be at least one");
    end

    // converter domain: hold result, announce by toggle
    logic [15:0] adc_hold_r;
    logic        adc_tog_r;

    always_ff @(posedge adc_clk) begin
        if (!adc_rst_n) begin
            adc_hold_r <= 16'h0000;
            adc_tog_r  <= 1'b0;
        end else if (adc_valid) begin
            adc_hold_r <= adc_result;
            adc_tog_r  <= ~adc_tog_r;
        end
    end

    logic        tog_m_r;
    logic        tog_s_r;
    logic        tog_q_r;
    logic [15:0] cur_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tog_m_r <= 1'b0;
            tog_s_r <= 1'b0;
            tog_q_r <= 1'b0;
            cur_r   <= 16'h0000;
        end else begin
            tog_m_r <= adc_tog_r;
            tog_s_r <= tog_m_r;
            tog_q_r <= tog_s_r;
            if (tog_s_r != tog_q_r) begin
                cur_r <= adc_hold_r;
            end
        end
    end

    // half-second time base
    logic [31:0] tick_cnt_r;
    logic        tick;

    assign tick = (tick_cnt_r == 32'(HALF_SEC_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // accumulators
    logic [7:0]  ctrl_r;
    logic [3:0]  clr_pulse_r;
    logic [16:0] mag;
    logic        acc_go;
    logic [3:0]  add_v;
    logic [31:0] acc_val [gauge_pkg::ACC_COUNT];

    assign mag    = cur_r[15] ? ({1'b0, ~cur_r} + 17'h1) : {1'b0, cur_r};
    assign acc_go = tick & ctrl_r[gauge_pkg::CTRL_ACC_EN];
    assign add_v[gauge_pkg::ACC_DIS_SUM]  = acc_go & cur_r[15];
    assign add_v[gauge_pkg::ACC_DIS_TIME] = acc_go & cur_r[15];
    assign add_v[gauge_pkg::ACC_CHG_SUM]  = acc_go & ~cur_r[15];
    assign add_v[gauge_pkg::ACC_CHG_TIME] = acc_go & ~cur_r[15];

    acc_if acc [gauge_pkg::ACC_COUNT] ();

    for (genvar i = 0; i < gauge_pkg::ACC_COUNT; i++) begin : g_acc
        localparam bit IS_TIME = (i == gauge_pkg::ACC_DIS_TIME) ||
                                 (i == gauge_pkg::ACC_CHG_TIME);
        assign acc[i].add   = add_v[i];
        assign acc[i].step  = IS_TIME ? 32'h1 : {15'h0, mag};
        assign acc[i].clear = clr_pulse_r[i];
        assign acc_val[i]   = acc[i].value;
        accum_unit u_acc (
            .clk   (clk),
            .rst_n (rst_n),
            .port  (acc[i])
        );
    end

    // bus pin synchronisers and condition detection
    logic scl_m_r;
    logic scl_s_r;
    logic scl_q_r;
    logic sda_m_r;
    logic sda_s_r;
    logic sda_q_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;

    // data moving while clock high is a condition, not data
    assign start_c  = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
    assign stop_c   = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
    assign scl_rise = scl_s_r & ~scl_q_r;
    assign scl_fall = ~scl_s_r & scl_q_r;

    // link state
    gauge_pkg::link_state_t state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  sh_r;
    logic [1:0]  byte_idx_r;
    logic        rw_r;
    logic [11:0] ptr_r;
    logic        drive_low_r;
    logic        mack_r;
    logic [1:0]  nv_cnt_r;
    logic        bus_act_r;
    logic [7:0]  crc_r;
    logic        pend_vld_r;
    logic [7:0]  pend_data_r;
    logic [11:0] pend_ptr_r;
    logic [7:0]  crc_pend_r;
    logic [31:0] nv_busy_cnt_r;
    logic        pec_err_r;
    logic [7:0]  sram [gauge_pkg::SRAM_BYTES];
    logic [7:0]  nv   [gauge_pkg::NV_BYTES];

    logic nv_busy;
    logic pec_en;

    assign nv_busy = (nv_busy_cnt_r != 32'h0);
    assign pec_en  = ctrl_r[gauge_pkg::CTRL_PEC_EN];

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int b = 0; b < 8; b++) begin
            x = x[7] ? ((x << 1) ^ gauge_pkg::CRC_POLY) : (x << 1);
        end
        return x;
    endfunction

    // read data for the current pointer
    logic [7:0] rd_byte;
    logic [9:0] ra;

    assign ra = ptr_r[9:0];

    always_comb begin
        rd_byte = 8'h00;
        if (ptr_r[11:10] == gauge_pkg::BANK_NV) begin
            if (ra[9:8] == 2'h0) begin
                rd_byte = nv[ra[7:0]];
            end
        end else if (ptr_r[11:10] == gauge_pkg::BANK_REG) begin
            if (ra <= gauge_pkg::SRAM_LAST) begin
                rd_byte = sram[ra[4:0]];
            end else if (ra >= gauge_pkg::ACC_FIRST && ra <= gauge_pkg::ACC_LAST) begin
                rd_byte = acc_val[ra[3:2]][8 * ra[1:0] +: 8];
            end else if (ra == gauge_pkg::CTRL_ADDR) begin
                rd_byte = ctrl_r;
            end else if (ra == gauge_pkg::STATUS_ADDR) begin
                rd_byte = {6'h00, pec_err_r, nv_busy};
            end else if (ra[9:1] == gauge_pkg::CUR_LO_ADDR[9:1]) begin
                rd_byte = cur_r[8 * ra[0] +: 8];
            end
        end
    end

    // acknowledge decision for the byte just received
    logic byte_done;
    logic ack_c;

    assign byte_done = scl_fall & (state_r == gauge_pkg::ST_RECV) & (bit_cnt_r == 4'h8);

    always_comb begin
        ack_c = 1'b1;
        unique case (byte_idx_r)
            2'h0: ack_c = (sh_r[7:1] == SLAVE_ADDR) &&
                          !(sh_r[0] && ptr_r[11:10] == gauge_pkg::BANK_NV && nv_busy);
            2'h1: ack_c = 1'b1;
            2'h2: ack_c = !(ptr_r[11:10] == gauge_pkg::BANK_NV && nv_busy);
            2'h3: ack_c = !(ptr_r[11:10] == gauge_pkg::BANK_NV &&
                            (nv_busy || nv_cnt_r >= (pec_en ? 2'h2 : 2'h1)));
        endcase
    end

    // committed writes; with checking on, each byte waits for the next
    logic        data_in;
    logic        wr_fire;
    logic [11:0] wr_ptr;
    logic [7:0]  wr_data;

    assign data_in  = byte_done & (byte_idx_r == 2'h3) & ack_c;
    assign wr_fire  = data_in & (~pec_en | pend_vld_r);
    assign wr_ptr   = pec_en ? pend_ptr_r : ptr_r;
    assign wr_data  = pec_en ? pend_data_r : sh_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r     <= gauge_pkg::ST_IDLE;
            bit_cnt_r   <= 4'h0;
            sh_r        <= 8'h00;
            byte_idx_r  <= 2'h0;
            rw_r        <= 1'b0;
            ptr_r       <= 12'h000;
            drive_low_r <= 1'b0;
            mack_r      <= 1'b0;
            nv_cnt_r    <= 2'h0;
            bus_act_r   <= 1'b0;
            crc_r       <= 8'h00;
            pend_vld_r  <= 1'b0;
            pend_data_r <= 8'h00;
            pend_ptr_r  <= 12'h000;
            crc_pend_r  <= 8'h00;
        end else if (start_c) begin
            state_r     <= gauge_pkg::ST_RECV;
            bit_cnt_r   <= 4'h0;
            byte_idx_r  <= 2'h0;
            drive_low_r <= 1'b0;
            nv_cnt_r    <= 2'h0;
            bus_act_r   <= 1'b1;
            pend_vld_r  <= 1'b0;
            if (!bus_act_r) begin
                crc_r <= 8'h00;
            end
        end else if (stop_c) begin
            state_r     <= gauge_pkg::ST_IDLE;
            drive_low_r <= 1'b0;
            bus_act_r   <= 1'b0;
            pend_vld_r  <= 1'b0;
        end else begin
            unique case (state_r)
                gauge_pkg::ST_IDLE: begin
                    drive_low_r <= 1'b0;
                end
                gauge_pkg::ST_RECV: begin
                    if (scl_rise && bit_cnt_r != 4'h8) begin
                        sh_r      <= {sh_r[6:0], sda_s_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        crc_r <= crc8(crc_r, sh_r);
                        if (ack_c) begin
                            state_r     <= gauge_pkg::ST_ACK_OUT;
                            drive_low_r <= 1'b1;
                            if (byte_idx_r != 2'h3) begin
                                byte_idx_r <= byte_idx_r + 2'h1;
                            end
                            unique case (byte_idx_r)
                                2'h0: rw_r <= sh_r[0];
                                2'h1: ptr_r[11:8] <= sh_r[3:0];
                                2'h2: ptr_r[7:0] <= sh_r;
                                2'h3: begin
                                    ptr_r[9:0] <= ptr_r[9:0] + 10'h1;
                                    pend_vld_r  <= pec_en;
                                    pend_data_r <= sh_r;
                                    pend_ptr_r  <= ptr_r;
                                    crc_pend_r  <= crc_r;
                                    if (ptr_r[11:10] == gauge_pkg::BANK_NV) begin
                                        nv_cnt_r <= nv_cnt_r + 2'h1;
                                    end
                                end
                            endcase
                        end else begin
                            state_r <= gauge_pkg::ST_IDLE;
                        end
                    end
                end
                gauge_pkg::ST_ACK_OUT: begin
                    if (scl_fall) begin
                        drive_low_r <= 1'b0;
                        bit_cnt_r   <= 4'h0;
                        if (rw_r && byte_idx_r == 2'h1) begin
                            state_r     <= gauge_pkg::ST_SEND;
                            sh_r        <= rd_byte;
                            drive_low_r <= ~rd_byte[7];
                            ptr_r[9:0]  <= ptr_r[9:0] + 10'h1;
                            crc_r       <= crc8(crc_r, rd_byte);
                        end else begin
                            state_r <= gauge_pkg::ST_RECV;
                        end
                    end
                end
                gauge_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h7) begin
                            state_r     <= gauge_pkg::ST_ACK_IN;
                            drive_low_r <= 1'b0;
                        end else begin
                            sh_r        <= {sh_r[6:0], 1'b0};
                            drive_low_r <= ~sh_r[6];
                            bit_cnt_r   <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                gauge_pkg::ST_ACK_IN: begin
                    if (scl_rise) begin
                        mack_r <= ~sda_s_r;
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r) begin
                            state_r     <= gauge_pkg::ST_SEND;
                            sh_r        <= rd_byte;
                            drive_low_r <= ~rd_byte[7];
                            ptr_r[9:0]  <= ptr_r[9:0] + 10'h1;
                            crc_r       <= crc8(crc_r, rd_byte);
                        end else begin
                            state_r     <= gauge_pkg::ST_IDLE;
                            drive_low_r <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_r     <= gauge_pkg::ST_IDLE;
                    drive_low_r <= 1'b0;
                end
            endcase
        end
    end

    // pin drive: open drain, only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = drive_low_r;

    // memories: a bus write stores a byte, and an nv bank write also starts the busy count
    always_ff @(posedge clk) begin
        if (wr_fire && wr_ptr[11:10] == gauge_pkg::BANK_REG && wr_ptr[9:0] <= gauge_pkg::SRAM_LAST) begin
            sram[wr_ptr[4:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_fire && wr_ptr[11:10] == gauge_pkg::BANK_NV && wr_ptr[9:8] == 2'h0) begin
            nv[wr_ptr[7:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_busy_cnt_r <= 32'h0;
        end else if (wr_fire && wr_ptr[11:10] == gauge_pkg::BANK_NV && wr_ptr[9:8] == 2'h0) begin
            nv_busy_cnt_r <= 32'(NV_WRITE_CYCLES);
        end else if (nv_busy) begin
            nv_busy_cnt_r <= nv_busy_cnt_r - 32'h1;
        end
    end

    // control, one-shot clears, checking status
    logic reg_wr;

    assign reg_wr = wr_fire & (wr_ptr[11:10] == gauge_pkg::BANK_REG);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r      <= gauge_pkg::CTRL_RST;
            clr_pulse_r <= 4'h0;
        end else begin
            clr_pulse_r <= 4'h0;
            if (reg_wr && wr_ptr[9:0] == gauge_pkg::CTRL_ADDR) begin
                ctrl_r <= wr_data;
            end
            if (reg_wr && wr_ptr[9:0] == gauge_pkg::CLEAR_ADDR) begin
                clr_pulse_r <= wr_data[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pec_err_r <= 1'b0;
        end else if ((start_c | stop_c) & pend_vld_r & pec_en & (pend_data_r != crc_pend_r)) begin
            pec_err_r <= 1'b1;
        end else if (reg_wr && wr_ptr[9:0] == gauge_pkg::STATUS_ADDR) begin
            pec_err_r <= 1'b0;
        end
    end
endmodule

/* File: sim/gauge_checker.sv */
// port-level assertions for the two-wire gauge slave
module gauge_checker #(
    parameter logic [6:0] SLAVE_ADDR = gauge_pkg::SLAVE_ADDR_DFLT
) (
    input  wire logic        clk,        // core clock
    input  wire logic        rst_n,      // core reset, active low
    input  wire logic        adc_clk,    // converter clock
    input  wire logic        adc_rst_n,  // converter reset, active low
    input  wire logic [15:0] adc_result, // current result
    input  wire logic        adc_valid,  // result strobe
    input  wire logic        scl_i,      // serial clock level
    input  wire logic        sda_i,      // serial data level
    input  wire logic        sda_o,      // data drive value
    input  wire logic        sda_oe      // data pull-low enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bits_r;
    logic [7:0] shift_r;
    logic [5:0] quiet_r;
    logic       rise, start, stop, hit, miss;
    assign rise  = scl_i & ~scl_q;
    assign start = scl_i & scl_q & sda_q & ~sda_i;
    assign stop  = scl_i & scl_q & ~sda_q & sda_i;
    assign hit   = rise && bits_r == 4'h7 && shift_r[6:0] == SLAVE_ADDR;
    assign miss  = rise && bits_r == 4'h7 && shift_r[6:0] != SLAVE_ADDR;
    always_ff @(posedge clk) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
    end
    // counts bits of the first byte after each start
    always_ff @(posedge clk) begin
        if (!rst_n || start) bits_r <= 4'h0;
        else if (rise && bits_r != 4'h8) bits_r <= bits_r + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (rise) shift_r <= {shift_r[6:0], sda_i};
    end
    always_ff @(posedge clk) begin
        if (!rst_n) quiet_r <= 6'h00;
        else if (miss) quiet_r <= 6'h28;
        else if (quiet_r != 6'h00) quiet_r <= quiet_r - 6'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence ack_soon;
        ##[1:40] sda_oe;
    endsequence
    sequence idle8;
        !sda_oe [*8];
    endsequence
    drive_low_a: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !sda_oe)
        else $error("data driven during reset");
    hold_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    rise_low_a: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data pulled low while clock high");
    fall_low_a: assert property ($fell(sda_oe) |-> !scl_i)
        else $error("data released while clock high");
    addr_ack_a: assert property (hit |-> ack_soon)
        else $error("own address not acknowledged");
    addr_miss_a: assert property (quiet_r != 6'h00 |-> !sda_oe)
        else $error("foreign address acknowledged");
    start_quiet_a: assert property (start |-> idle8)
        else $error("data driven at start");
    stop_quiet_a: assert property (stop |=> idle8)
        else $error("data driven after stop");
endmodule

bind gauge_smbus_slave_memory_accum gauge_checker #(.SLAVE_ADDR(SLAVE_ADDR)) chk (
    .clk(clk), .rst_n(rst_n), .adc_clk(adc_clk), .adc_rst_n(adc_rst_n),
    .adc_result(adc_result), .adc_valid(adc_valid), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe));

/* File: sim/smbus_host.sv */
// two-wire host master model driving clock and data
module smbus_host (
    input  wire logic clk,      // pacing clock
    input  wire logic sda_line, // resolved data wire
    output logic      scl,      // serial clock, high when idle
    output logic      sda_low   // high while pulling data low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 10;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold;
        repeat (HALF) @(negedge clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_low = ~b;
        hold();
        scl = 1'b1;
        hold();
        s = sda_line;
        scl = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic start;
        sda_low = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic stop;
        sda_low = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b0;
        hold();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s);
            d = {d[6:0], s};
        end
        bit_io(last, s);
    endtask
endmodule

/* File: sim/gauge_smbus_slave_memory_accum_tb_top.sv */
// self-checking bench for the two-wire gauge slave
module gauge_smbus_slave_memory_accum_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADDR = 7'h2A; // arbitrary test address
    localparam int         TICK = 3000;
    logic        clk, rst_n, adc_clk, adc_rst_n, adc_valid, scl, host_low, sda_o, sda_oe;
    logic [15:0] adc_result;
    wire         sda_line = ~sda_oe & ~host_low;
    int          failures, samples_checked;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        adc_clk = 1'b0;
        #5;
        forever #6 adc_clk = ~adc_clk;
    end
    gauge_smbus_slave_memory_accum #(.SLAVE_ADDR(ADDR), .HALF_SEC_CYCLES(TICK),
        .NV_WRITE_CYCLES(6000)) DUT (.clk(clk), .rst_n(rst_n), .adc_clk(adc_clk),
        .adc_rst_n(adc_rst_n), .adc_result(adc_result), .adc_valid(adc_valid),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
    smbus_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic ptr(input logic [1:0] bk, input logic [9:0] a, output logic ok);
        logic k;
        host.start();
        host.wr_byte({ADDR, 1'b0}, ok);
        host.wr_byte({4'h0, bk, a[9:8]}, k);
        ok &= k;
        host.wr_byte(a[7:0], k);
        ok &= k;
    endtask
    task automatic wr(input logic [1:0] bk, input logic [9:0] a, input logic [31:0] d,
                      input int n, output logic ok);
        logic k;
        ptr(bk, a, ok);
        for (int i = 0; i < n; i++) begin
            host.wr_byte(d[8*i+:8], k);
            ok &= k;
        end
        host.stop();
    endtask
    task automatic rd(input logic [1:0] bk, input logic [9:0] a, input int n,
                      output logic [31:0] d);
        logic       k;
        logic [7:0] b;
        d = 32'h0;
        ptr(bk, a, k);
        host.start();
        host.wr_byte({ADDR, 1'b1}, k);
        for (int i = 0; i < n; i++) begin
            host.rd_byte(i == n - 1, b);
            d[8*i+:8] = b;
        end
        host.stop();
    endtask
    task automatic nv_wait;
        logic [31:0] s;
        for (int i = 0; i < 40; i++) begin
            rd(2'h1, 10'h032, 1, s);
            if (s[0] === 1'b0) return;
        end
        check("nv busy end", 32'h1, 32'h0);
        end_of_test();
    endtask
    task automatic set_cur(input logic [15:0] v);
        @(negedge adc_clk);
        adc_result = v;
        adc_valid = 1'b1;
        @(negedge adc_clk);
        adc_valid = 1'b0;
    endtask
    task automatic t_bus;
        logic [31:0] d;
        logic        ok;
        host.start();
        host.wr_byte({ADDR ^ 7'h01, 1'b0}, ok);
        host.stop();
        check("foreign address ack", 32'(ok), 32'h0);
        wr(2'h1, 10'h01E, 32'h3CA5, 2, ok);
        check("sram write ack", 32'(ok), 32'h1);
        rd(2'h1, 10'h01E, 2, d);
        check("sram block read", d, 32'h3CA5);
        check("data released", 32'(sda_oe), 32'h0);
        rd(2'h2, 10'h000, 1, d);
        check("test bank read", d, 32'h0);
        $display("bus test done");
    endtask
    task automatic t_nv;
        logic [31:0] d;
        logic        ok;
        wr(2'h0, 10'h0FF, 32'h5A, 1, ok);
        check("nv write ack", 32'(ok), 32'h1);
        rd(2'h1, 10'h032, 1, d);
        check("nv busy flag", d, 32'h1);
        wr(2'h0, 10'h010, 32'h11, 1, ok);
        check("busy write ack", 32'(ok), 32'h0);
        ptr(2'h0, 10'h0FF, ok);
        host.stop();
        check("busy read ack", 32'(ok), 32'h0);
        wr(2'h1, 10'h000, 32'h77, 1, ok);
        check("busy sram ack", 32'(ok), 32'h1);
        rd(2'h1, 10'h000, 1, d);
        check("busy sram data", d, 32'h77);
        nv_wait();
        rd(2'h0, 10'h0FF, 1, d);
        check("nv read back", d, 32'h5A);
        wr(2'h0, 10'h020, 32'hBBAA, 2, ok);
        check("nv second byte ack", 32'(ok), 32'h0);
        nv_wait();
        rd(2'h0, 10'h020, 1, d);
        check("nv first byte", d, 32'hAA);
        $display("nv test done");
    endtask
    task automatic t_acc;
        logic [31:0] t, c, v;
        logic        ok;
        set_cur(16'hFED4);
        wr(2'h1, 10'h031, 32'h0F, 1, ok);
        wr(2'h1, 10'h030, 32'h01, 1, ok);
        repeat (2 * TICK + 1000) @(negedge clk);
        wr(2'h1, 10'h030, 32'h00, 1, ok);
        rd(2'h1, 10'h024, 4, t);
        check("discharge ticks", 32'(t == 32'h2 || t == 32'h3), 32'h1);
        rd(2'h1, 10'h020, 4, v);
        check("discharge sum", v, t * 300);
        rd(2'h1, 10'h028, 4, v);
        check("charge sum held", v, 32'h0);
        set_cur(16'h0190);
        wr(2'h1, 10'h031, 32'h01, 1, ok);
        wr(2'h1, 10'h030, 32'h01, 1, ok);
        repeat (2 * TICK + 1000) @(negedge clk);
        wr(2'h1, 10'h030, 32'h00, 1, ok);
        rd(2'h1, 10'h02C, 4, c);
        check("charge ticks", 32'(c == 32'h2 || c == 32'h3), 32'h1);
        rd(2'h1, 10'h028, 4, v);
        check("charge sum", v, c * 400);
        rd(2'h1, 10'h020, 4, v);
        check("discharge sum cleared", v, 32'h0);
        rd(2'h1, 10'h024, 4, v);
        check("discharge time kept", v, t);
        rd(2'h1, 10'h031, 1, v);
        check("clear bits return", v, 32'h0);
        wr(2'h1, 10'h030, 32'h02, 1, ok);
        wr(2'h1, 10'h000, 32'h0F00, 2, ok);
        rd(2'h1, 10'h032, 1, v);
        check("pec good status", v, 32'h0);
        wr(2'h1, 10'h000, 32'h0000, 2, ok);
        rd(2'h1, 10'h032, 1, v);
        check("pec error flag", v, 32'h2);
        $display("accumulator test done");
    endtask
    initial begin
        failures = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        adc_rst_n = 1'b0;
        adc_result = 16'h0000;
        adc_valid = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        adc_rst_n = 1'b1;
        t_bus();
        t_nv();
        t_acc();
        end_of_test();
    end
endmodule
